/* File: hw/led_duty_regs.sv */
// Purpose: twelve 8-bit luminance duty registers and their dimmed outputs
// Assumes: register port is the decoded output of the serial bus front end
// Notes: new codes take effect at the next period start, so no short pulses

`timescale 1ns/1ps

// Summary of operation
// - one 8-bit code per channel, drives itself
// - output active code/256 of each period
// - code zero keeps output off all period
// - code FF leaves one off slot per period
// - all codes and outputs zero after reset
// - codes at 0Dh..18h, red-green-blue order
module led_duty_regs (
  input wire logic clk_sys,                     // 25 MHz system clock
  input wire logic reset,                       // sync reset, high
  input led_duty_pkg::reg_req_t regReq,         // register read/write
  output led_duty_pkg::reg_rsp_t regRsp,        // ack, error, read data
  output logic [led_duty_pkg::NUM_CH-1:0] dimOut,  // dimmed channel levels
  output logic periodStart                      // last clock of period
);
  import led_duty_pkg::*;

  // --------------------------------------------------------------------
  // state and period counter
  // --------------------------------------------------------------------
  duty_state_t st_ff;
  duty_state_t nxt_st;
  duty_t slotCount;
  logic slotTick;
  logic wrapNext;
  logic [NUM_CH-1:0] chSel;
  logic [NUM_CH-1:0] chActive;
  logic addrHit;
  duty_t rdMux;

  duty_slot_counter u_slot (
    .clk_sys(clk_sys),
    .reset(reset),
    .slotCount(slotCount),
    .slotTick(slotTick),
    .wrapNext(wrapNext)
  );

  // --------------------------------------------------------------------
  // per-channel decode and compare
  // --------------------------------------------------------------------
  // each channel compares only its own latched code with the slot count
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign chSel[i] = (regReq.addr == DUTY_OFS[i]);
    assign chActive[i] = (slotCount < st_ff.live[i]);
  end

  assign addrHit = |chSel;

  // read mux: one-hot select, unmapped reads return zero
  always_comb begin
    rdMux = '0;
    for (int k = 0; k < NUM_CH; k++) begin
      if (chSel[k]) begin
        rdMux = st_ff.duty[k];
      end
    end
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  // a read and a write in one cycle return the old value, then store
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp.ack = regReq.rdEn || regReq.wrEn;
    nxt_st.rsp.err = (regReq.rdEn || regReq.wrEn) && !addrHit;
    nxt_st.rsp.rdData = (regReq.rdEn && addrHit) ? rdMux : DUTY_RESET;
    for (int k = 0; k < NUM_CH; k++) begin
      if (regReq.wrEn && chSel[k]) begin
        nxt_st.duty[k] = regReq.wrData;
      end
    end
    // latch codes for the next period only at the wrap, so a write in
    // mid-period never cuts a pulse short or doubles it
    if (wrapNext) begin
      nxt_st.live = nxt_st.duty;
    end
    nxt_st.dim = chActive;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff.duty <= {NUM_CH{DUTY_RESET}};
      st_ff.live <= {NUM_CH{DUTY_RESET}};
      st_ff.dim <= '0;
      st_ff.rsp <= '{ack: 1'b0, err: 1'b0, rdData: DUTY_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign regRsp = st_ff.rsp;
  assign dimOut = st_ff.dim;
  assign periodStart = wrapNext;

  // --------------------------------------------------------------------
  // checking helpers
  // --------------------------------------------------------------------
  // counts active slots of channel 0 across one period
  logic [8:0] hiCnt_ff;

  always_ff @(posedge clk_sys) begin
    if (reset || wrapNext) begin
      hiCnt_ff <= HI_RESET;
    end else if (slotTick && chActive[0]) begin
      hiCnt_ff <= hiCnt_ff + 9'h001;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_code_isolated: assert property (
    !(regReq.wrEn && chSel[0]) |=> $stable(st_ff.duty[0]))
    else $error("channel 0 code changed without its own write");

  a_period_duty: assert property (
    wrapNext |-> (hiCnt_ff + {8'h00, chActive[0]}) == {1'b0, st_ff.live[0]})
    else $error("active slot count differs from code");

  a_zero_off: assert property (
    st_ff.live[0] == DUTY_RESET [*2] |-> !dimOut[0])
    else $error("zero code let the output go active");

  a_full_gap: assert property (
    st_ff.live[0] == DUTY_FULL && slotCount == SLOT_LAST |=> !dimOut[0])
    else $error("full code missed its one inactive slot");

  a_full_on: assert property (
    st_ff.live[0] == DUTY_FULL && slotCount != SLOT_LAST |=> dimOut[0])
    else $error("full code went inactive early");

  a_reset_clear: assert property (disable iff (1'b0)
    reset |=> st_ff.duty == '0 && dimOut == '0 && regRsp == '0)
    else $error("state not cleared by reset");

  a_write_map: assert property (
    regReq.wrEn && regReq.addr == OFS_RED7_DUTY
    |=> st_ff.duty[NUM_CH-1] == $past(regReq.wrData))
    else $error("write to last offset missed red7 code");

  a_read_map: assert property (
    regReq.rdEn && !regReq.wrEn && regReq.addr == OFS_GREEN3_DUTY
    |=> regRsp.ack && !regRsp.err && regRsp.rdData == st_ff.duty[0])
    else $error("read of first offset did not return green3 code");

  a_unmapped: assert property (
    regReq.rdEn && !addrHit |=> regRsp.err && regRsp.rdData == DUTY_RESET)
    else $error("unmapped read not flagged");

  a_live_hold: assert property (
    !wrapNext |=> $stable(st_ff.live))
    else $error("latched code changed inside a period");

  a_below_code: assert property (
    slotCount < st_ff.live[3] |=> dimOut[3])
    else $error("channel 3 inactive while slot below code");

  // --------------------------------------------------------------------
  // covers
  // --------------------------------------------------------------------
  c_write_any: cover property (regReq.wrEn && addrHit);
  c_full_period: cover property (wrapNext && st_ff.live[0] == DUTY_FULL);
  c_mid_duty: cover property (wrapNext && hiCnt_ff == 9'h080);
  c_unmapped: cover property (regReq.rdEn && !addrHit);

endmodule : led_duty_regs

/* File: common/led_duty_pkg.sv */
// Purpose: shared constants and carriers for the LED duty registers and dimmer
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes: offsets are byte offsets on the device's internal register port

package led_duty_pkg;

  // --------------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------------
  localparam int NUM_CH = 12;  // green3 .. red7
  localparam int DUTY_W = 8;
  localparam int ADDR_W = 8;

  typedef logic [ADDR_W-1:0] reg_addr_t;
  typedef logic [DUTY_W-1:0] duty_t;

  // --------------------------------------------------------------------
  // register offsets, in red, green, blue order per LED group
  // --------------------------------------------------------------------
  localparam reg_addr_t OFS_GREEN3_DUTY = 8'h0D;
  localparam reg_addr_t OFS_BLUE3_DUTY = 8'h0E;
  localparam reg_addr_t OFS_RED4_DUTY = 8'h0F;
  localparam reg_addr_t OFS_GREEN4_DUTY = 8'h10;
  localparam reg_addr_t OFS_BLUE4_DUTY = 8'h11;
  localparam reg_addr_t OFS_RED5_DUTY = 8'h12;
  localparam reg_addr_t OFS_GREEN5_DUTY = 8'h13;
  localparam reg_addr_t OFS_BLUE5_DUTY = 8'h14;
  localparam reg_addr_t OFS_RED6_DUTY = 8'h15;
  localparam reg_addr_t OFS_GREEN6_DUTY = 8'h16;
  localparam reg_addr_t OFS_BLUE6_DUTY = 8'h17;
  localparam reg_addr_t OFS_RED7_DUTY = 8'h18;

  // channel index i sits at DUTY_OFS[i]
  localparam reg_addr_t DUTY_OFS [NUM_CH] = '{
    OFS_GREEN3_DUTY, OFS_BLUE3_DUTY, OFS_RED4_DUTY, OFS_GREEN4_DUTY,
    OFS_BLUE4_DUTY, OFS_RED5_DUTY, OFS_GREEN5_DUTY, OFS_BLUE5_DUTY,
    OFS_RED6_DUTY, OFS_GREEN6_DUTY, OFS_BLUE6_DUTY, OFS_RED7_DUTY};

  // --------------------------------------------------------------------
  // reset values and counts
  // --------------------------------------------------------------------
  localparam duty_t DUTY_RESET = 8'h00;
  localparam duty_t DUTY_FULL = 8'hFF;   // largest code, 255/256
  localparam duty_t SLOT_RESET = 8'h00;
  localparam duty_t SLOT_LAST = 8'hFF;   // 256 slots per period
  localparam logic [3:0] SLOT_DIV_CLKS = 4'h1;  // clocks per slot
  localparam logic [3:0] DIV_RESET = 4'h0;
  localparam logic [8:0] HI_RESET = 9'h000;

  // --------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    reg_addr_t addr;
    duty_t wrData;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    duty_t rdData;
  } reg_rsp_t;

  typedef struct packed {
    logic [3:0] div;
    duty_t slot;
  } slot_state_t;

  typedef struct packed {
    logic [NUM_CH-1:0][DUTY_W-1:0] duty;
    logic [NUM_CH-1:0][DUTY_W-1:0] live;
    logic [NUM_CH-1:0] dim;
    reg_rsp_t rsp;
  } duty_state_t;

endpackage : led_duty_pkg

/* File: hw/duty_slot_counter.sv */
// Purpose: free-running 256-slot dimming period counter with slot divider
// Assumes: one clock, synchronous active-high reset
// Notes: wrapNext marks the last clock of slot 255

`timescale 1ns/1ps

module duty_slot_counter (
  input wire logic clk_sys,                  // system clock
  input wire logic reset,                    // sync reset, high
  output led_duty_pkg::duty_t slotCount,     // current slot 0..255
  output logic slotTick,                     // last clock of a slot
  output logic wrapNext                      // last clock of the period
);
  import led_duty_pkg::*;

  slot_state_t st_ff;
  slot_state_t nxt_st;

  // --------------------------------------------------------------------
  // divider and slot counter
  // --------------------------------------------------------------------
  // the divider lets the slot rate drop without touching the compare logic
  always_comb begin
    nxt_st = st_ff;
    slotTick = (st_ff.div == SLOT_DIV_CLKS - 4'h1);
    wrapNext = slotTick && (st_ff.slot == SLOT_LAST);
    if (slotTick) begin
      nxt_st.div = DIV_RESET;
      nxt_st.slot = st_ff.slot + 8'h01;  // wraps 255 -> 0
    end else begin
      nxt_st.div = st_ff.div + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '{div: DIV_RESET, slot: SLOT_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign slotCount = st_ff.slot;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_slot_wraps: assert property (@(posedge clk_sys) disable iff (reset)
    wrapNext |=> slotCount == SLOT_RESET)
    else $error("slot counter did not wrap to zero");

  a_slot_steps: assert property (@(posedge clk_sys) disable iff (reset)
    slotTick && !wrapNext |=> slotCount == $past(slotCount) + 8'h01)
    else $error("slot counter skipped a slot");

endmodule : duty_slot_counter

/* File: testbench/led_load_model.sv */
// Purpose: load model of the twelve dimmed LED channels
// Assumes: a high level lights the LED, periodStart marks the last clock of a period
// Notes: lit clocks are counted over one whole period, so a lagging output still sums right

`timescale 1ns/1ps

module led_load_model (
  input wire logic clk_sys,                                 // system clock
  input wire logic reset,                                   // sync reset, high
  input wire logic [led_duty_pkg::NUM_CH-1:0] dimOut,       // channel levels
  input wire logic periodStart,                             // last clock of period
  output logic [led_duty_pkg::NUM_CH-1:0][8:0] onCount      // lit clocks, last period
);
  import led_duty_pkg::*;

  logic [NUM_CH-1:0][8:0] accumCount;

  // ------------------------------------------------------------------
  // light integration
  // ------------------------------------------------------------------
  // nine bits so a fully lit period of 256 clocks could still show
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      accumCount <= '0;
      onCount <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (periodStart) begin
          onCount[i] <= accumCount[i] + 9'(dimOut[i]);
          accumCount[i] <= 9'h000;
        end else begin
          accumCount[i] <= accumCount[i] + 9'(dimOut[i]);
        end
      end
    end
  end
endmodule : led_load_model

/* File: testbench/test_led_duty_regs.sv */
// Purpose: self-checking bench for the twelve duty registers and their dimmed outputs
// Assumes: inputs change at the falling edge, answers are read one cycle later
// Notes: duty is judged from whole periods counted by the load model

`timescale 1ns/1ps

module test_led_duty_regs;
  import led_duty_pkg::*;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  reg_req_t regReq = '0;
  reg_rsp_t regRsp;
  logic [NUM_CH-1:0] dimOut;
  logic periodStart;
  logic [NUM_CH-1:0][8:0] onCount;
  int errors = 0;
  int tests_run = 0;
  duty_t codes [NUM_CH];

  always #20 clk_sys = ~clk_sys;

  led_duty_regs u_dut (.clk_sys(clk_sys), .reset(reset), .regReq(regReq), .regRsp(regRsp),
    .dimOut(dimOut), .periodStart(periodStart));
  led_load_model u_leds (.clk_sys(clk_sys), .reset(reset), .dimOut(dimOut),
    .periodStart(periodStart), .onCount(onCount));

  // ------------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [8:0] expVal, input logic [8:0] gotVal);
    tests_run++;
    if (gotVal !== expVal) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, expVal, gotVal);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // one request, then the answer one cycle later; ack comes even for an unmapped offset
  task automatic reg_access(input logic wr, input reg_addr_t addr, input duty_t data,
                            input logic expErr, input duty_t expRd);
    @(negedge clk_sys);
    regReq <= '{wrEn: wr, rdEn: !wr, addr: addr, wrData: data};
    @(negedge clk_sys);
    regReq <= '0;
    check("ack", 9'h001, {8'h00, regRsp.ack});
    check("err", {8'h00, expErr}, {8'h00, regRsp.err});
    check($sformatf("rdData@%h", addr), {1'b0, expRd}, {1'b0, regRsp.rdData});
  endtask : reg_access

  // bounded wait for the last clock of a period
  task automatic wait_period();
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (periodStart !== 1'b1 && n < 300);
    if (periodStart !== 1'b1) begin
      errors++;
      $display("CHECK FAILED periodStart expected 1 seen 0");
      tally_and_finish();
    end
  endtask : wait_period

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_reset();
    for (int i = 0; i < NUM_CH; i++) reg_access(1'b0, DUTY_OFS[i], 8'h00, 1'b0, DUTY_RESET);
    reg_access(1'b0, 8'h0C, 8'h00, 1'b1, 8'h00);
    reg_access(1'b0, 8'h19, 8'h00, 1'b1, 8'h00);
    wait_period();
    wait_period();
    for (int i = 0; i < NUM_CH; i++) check("onCount", 9'h000, onCount[i]);
    check("dimOut", 9'h000, {8'h00, |dimOut});
    $display("test_reset done");
  endtask : test_reset

  // distinct codes per channel, with the two end codes among them
  task automatic test_readback();
    for (int i = 0; i < NUM_CH; i++) codes[i] = 8'(i * 19 + 1);
    codes[0] = 8'h00;
    codes[1] = DUTY_FULL;
    for (int i = 0; i < NUM_CH; i++) reg_access(1'b1, DUTY_OFS[i], codes[i], 1'b0, 8'h00);
    reg_access(1'b1, 8'h19, 8'h5A, 1'b1, 8'h00);
    reg_access(1'b1, 8'h0C, 8'hA5, 1'b1, 8'h00);
    for (int i = 0; i < NUM_CH; i++) reg_access(1'b0, DUTY_OFS[i], 8'h00, 1'b0, codes[i]);
    $display("test_readback done");
  endtask : test_readback

  // lit clocks per 256-clock period must equal each channel's own code
  task automatic test_duty();
    repeat (3) wait_period();
    for (int i = 0; i < NUM_CH; i++) check($sformatf("onCount%0d", i), {1'b0, codes[i]}, onCount[i]);
    check("onCount zero code", 9'h000, onCount[0]);
    check("onCount full code", 9'h0FF, onCount[1]);
    $display("test_duty done");
  endtask : test_duty

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk_sys);
    reset <= 1'b0;
    test_reset();
    test_readback();
    test_duty();
    tally_and_finish();
  end
endmodule : test_led_duty_regs
